// >>> core/core_timing_regs.vh
// constants for the instruction timing and decode core
// assumes inclusion by both the core and its field decoder
`ifndef CORE_TIMING_REGS_VH
`define CORE_TIMING_REGS_VH

// word and path widths
`define INSTR_W 14
`define PC_W 15
`define PC_RESET 15'h0000
`define NOP_WORD 14'h0000
// oscillator periods per instruction cycle, and the phase that closes it
`define OSC_PER_INSTR 4
`define PH_READ 2'h1
`define PH_CALC 2'h2
`define PH_LAST 2'h3
// file space: highest address, indirect windows for pointer 0 and 1
`define FILE_MAX 7'h7F
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01
// pointer update modes
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3
// operation identifiers, byte ops first so ranges classify them
`define OP_ADDWF 6'h00
`define OP_ADDWFC 6'h01
`define OP_ANDWF 6'h02
`define OP_ASRF 6'h03
`define OP_LSLF 6'h04
`define OP_LSRF 6'h05
`define OP_CLRF 6'h06
`define OP_CLRW 6'h07
`define OP_COMF 6'h08
`define OP_DECF 6'h09
`define OP_INCF 6'h0A
`define OP_IORWF 6'h0B
`define OP_MOVF 6'h0C
`define OP_MOVWF 6'h0D
`define OP_RLF 6'h0E
`define OP_RRF 6'h0F
`define OP_SUBWF 6'h10
`define OP_SUBWFB 6'h11
`define OP_SWAPF 6'h12
`define OP_XORWF 6'h13
`define OP_DEC_ZSKIP 6'h14
`define OP_INC_ZSKIP 6'h15
`define OP_BCF 6'h16
`define OP_BSF 6'h17
`define OP_BIT_CLR_SKIP 6'h18
`define OP_BIT_SET_SKIP 6'h19
`define OP_ADDLW 6'h1A
`define OP_ANDLW 6'h1B
`define OP_IORLW 6'h1C
`define OP_MOVLB 6'h1D
`define OP_MOVLP 6'h1E
`define OP_MOVLW 6'h1F
`define OP_SUBLW 6'h20
`define OP_XORLW 6'h21
`define OP_PC_OFS_JUMP 6'h22
`define OP_ACC_OFS_JUMP 6'h23
`define OP_CALL 6'h24
`define OP_ACC_CALL 6'h25
`define OP_ABS_JUMP 6'h26
`define OP_INT_EXIT 6'h27
`define OP_LIT_RETURN 6'h28
`define OP_RETURN 6'h29
`define OP_NOP 6'h2A
`define OP_CLRWDT 6'h2B
`define OP_SLEEP 6'h2C
`define OP_RESET 6'h2D
`define OP_OPTION 6'h2E
`define OP_TRIS 6'h2F
`define OP_ADDFSR 6'h30
`define OP_MOVIW 6'h31
`define OP_MOVIW_K 6'h32
`define OP_MOVWI 6'h33
`define OP_MOVWI_K 6'h34
`define OP_ILLEGAL 6'h3F

`endif

// >>> core/instr_field_decode.v
// operation and operand field decoder for one 14-bit instruction word
// assumes a word already fetched; purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "core_timing_regs.vh"

module instr_field_decode (
	// instruction word
	input wire [13:0] word,
	// decoded operation and operands
	output reg [5:0] op,
	output wire dest_sel,
	output wire [2:0] bit_sel,
	output wire [6:0] file_addr,
	output wire [10:0] literal,
	output wire ptr_idx,
	output wire [1:0] pointer_update_mode
);

	// operand fields
	assign dest_sel = word[7];
	assign bit_sel = word[9:7];
	assign file_addr = word[6:0] & `FILE_MAX;
	assign literal = word[10:0];
	assign pointer_update_mode = word[1:0];
	// pointer index sits low for the short indirect moves, bit 6 otherwise
	assign ptr_idx = (op == `OP_MOVIW || op == `OP_MOVWI) ? word[2] : word[6];

	// full instruction set match
	always @* begin
		casez (word)
			14'b00_0111_????_????: op = `OP_ADDWF;
			14'b11_1101_????_????: op = `OP_ADDWFC;
			14'b00_0101_????_????: op = `OP_ANDWF;
			14'b11_0111_????_????: op = `OP_ASRF;
			14'b11_0101_????_????: op = `OP_LSLF;
			14'b11_0110_????_????: op = `OP_LSRF;
			14'b00_0001_1???_????: op = `OP_CLRF;
			14'b00_0001_0000_00??: op = `OP_CLRW;
			14'b00_1001_????_????: op = `OP_COMF;
			14'b00_0011_????_????: op = `OP_DECF;
			14'b00_1010_????_????: op = `OP_INCF;
			14'b00_0100_????_????: op = `OP_IORWF;
			14'b00_1000_????_????: op = `OP_MOVF;
			14'b00_0000_1???_????: op = `OP_MOVWF;
			14'b00_1101_????_????: op = `OP_RLF;
			14'b00_1100_????_????: op = `OP_RRF;
			14'b00_0010_????_????: op = `OP_SUBWF;
			14'b11_1011_????_????: op = `OP_SUBWFB;
			14'b00_1110_????_????: op = `OP_SWAPF;
			14'b00_0110_????_????: op = `OP_XORWF;
			14'b00_1011_????_????: op = `OP_DEC_ZSKIP;
			14'b00_1111_????_????: op = `OP_INC_ZSKIP;
			14'b01_00??_????_????: op = `OP_BCF;
			14'b01_01??_????_????: op = `OP_BSF;
			14'b01_10??_????_????: op = `OP_BIT_CLR_SKIP;
			14'b01_11??_????_????: op = `OP_BIT_SET_SKIP;
			14'b11_1110_????_????: op = `OP_ADDLW;
			14'b11_1001_????_????: op = `OP_ANDLW;
			14'b11_1000_????_????: op = `OP_IORLW;
			14'b00_0000_001?_????: op = `OP_MOVLB;
			14'b11_0001_1???_????: op = `OP_MOVLP;
			14'b11_0000_????_????: op = `OP_MOVLW;
			14'b11_1100_????_????: op = `OP_SUBLW;
			14'b11_1010_????_????: op = `OP_XORLW;
			14'b11_001?_????_????: op = `OP_PC_OFS_JUMP;
			14'b00_0000_0000_1011: op = `OP_ACC_OFS_JUMP;
			14'b10_0???_????_????: op = `OP_CALL;
			14'b00_0000_0000_1010: op = `OP_ACC_CALL;
			14'b10_1???_????_????: op = `OP_ABS_JUMP;
			14'b00_0000_0000_1001: op = `OP_INT_EXIT;
			14'b11_0100_????_????: op = `OP_LIT_RETURN;
			14'b00_0000_0000_1000: op = `OP_RETURN;
			14'b00_0000_0000_0000: op = `OP_NOP;
			14'b00_0000_0110_0100: op = `OP_CLRWDT;
			14'b00_0000_0110_0011: op = `OP_SLEEP;
			14'b00_0000_0000_0001: op = `OP_RESET;
			14'b00_0000_0110_0010: op = `OP_OPTION;
			14'b00_0000_0110_01??: op = `OP_TRIS;
			14'b11_0001_0???_????: op = `OP_ADDFSR;
			14'b00_0000_0001_0???: op = `OP_MOVIW;
			14'b11_1111_0???_????: op = `OP_MOVIW_K;
			14'b00_0000_0001_1???: op = `OP_MOVWI;
			14'b11_1111_1???_????: op = `OP_MOVWI_K;
			default: op = `OP_ILLEGAL;
		endcase
	end

endmodule // instr_field_decode
`default_nettype wire

// >>> core/core_instruction_timing_decode.v
// instruction sequencer: fetch, four-phase timing, operand access, transfers
// assumes synchronous program memory, file space and return stack outside
`timescale 1ns/1ns
`default_nettype none
`include "core_timing_regs.vh"

module core_instruction_timing_decode (
	// clock and reset
	input wire ref_clk,
	input wire reset_n,
	// program memory
	output wire [14:0] pm_addr,
	input wire [13:0] pm_data,
	// file register space
	output wire [4:0] fr_bank,
	output wire [6:0] fr_addr,
	output wire fr_rd,
	output wire fr_wr,
	output wire [7:0] fr_wdata,
	input wire [7:0] fr_rdata,
	input wire carry_in,
	// indirect pointers
	input wire [1:0] ptr_in_pgm,
	output wire ptr_step,
	output wire ptr_add,
	output wire ptr_sel,
	output wire [1:0] ptr_mode,
	output wire [5:0] ptr_ofs,
	// return stack
	output wire stack_push,
	output wire [14:0] stack_ret_addr,
	output wire stack_pop,
	input wire [14:0] stack_top,
	// status of the sequencer
	output wire [1:0] osc_phase,
	output wire instr_cycle_end,
	output wire retire,
	output wire [5:0] retire_op,
	output wire illegal_op,
	output wire int_exit,
	output wire [7:0] acc
);

	// sequencer states
	localparam ST_EXEC = 3'b001;
	localparam ST_HOLD = 3'b010;
	localparam ST_FLUSH = 3'b100;
	localparam [1:0] PH_MAX = `PH_LAST; // last of the four phases

	reg [1:0] phase_q;
	reg [2:0] st_q;
	reg [14:0] pc_q;
	reg [13:0] ir_q;
	reg [7:0] w_q;
	reg [6:0] pclath_q;
	reg [4:0] bank_q;
	reg [7:0] res_q;
	reg skip_q;
	reg [7:0] alu_d;
	reg skip_d;
	reg jump_d;
	reg [14:0] target_d;

	wire [5:0] op;
	wire dsel;
	wire [2:0] bsel;
	wire [6:0] faddr;
	wire [10:0] lit;
	wire pidx;
	wire [1:0] pmode;

	// mask for the selected bit, shared by set, clear and test
	function [7:0] bit_mask;
		input [2:0] sel;
		begin
			bit_mask = 8'h01 << sel;
		end
	endfunction

	instr_field_decode u_dec (
		.word(ir_q),
		.op(op),
		.dest_sel(dsel),
		.bit_sel(bsel),
		.file_addr(faddr),
		.literal(lit),
		.ptr_idx(pidx),
		.pointer_update_mode(pmode)
	);

	// operation classes
	wire is_byte = op <= `OP_INC_ZSKIP;
	wire is_bitop = op >= `OP_BCF && op <= `OP_BIT_SET_SKIP;
	wire is_lit_w = (op >= `OP_ADDLW && op <= `OP_XORLW && op != `OP_MOVLB &&
		op != `OP_MOVLP) || op == `OP_LIT_RETURN;
	wire is_ind_move = op == `OP_MOVIW || op == `OP_MOVWI;
	wire is_ind_k = op == `OP_MOVIW_K || op == `OP_MOVWI_K;
	wire is_ind = is_ind_move || is_ind_k;
	wire names_file = (is_byte && op != `OP_CLRW) || is_bitop;
	// either window address, pointer 0 or 1 in bit 0
	wire win_hit = names_file && {faddr[6:1], 1'b0} == `WIN0_ADDR;
	wire n_eff = win_hit ? faddr[0] : pidx;

	// extra cycle for indirect access into program memory
	wire need_extra = (win_hit || is_ind) && ptr_in_pgm[n_eff];
	// the instruction really executes this cycle
	wire exe = (st_q == ST_EXEC && !need_extra) || st_q == ST_HOLD;
	wire q_end = phase_q == PH_MAX;
	wire wr_w = (is_byte && !dsel) || is_lit_w || op == `OP_MOVIW || op == `OP_MOVIW_K;
	wire wr_file = (is_byte && dsel) || op == `OP_BCF || op == `OP_BSF ||
		op == `OP_MOVWI || op == `OP_MOVWI_K;
	wire is_call = op == `OP_CALL || op == `OP_ACC_CALL;
	wire is_ret = op == `OP_RETURN || op == `OP_LIT_RETURN || op == `OP_INT_EXIT;

	// file access strobes: read in phase 1, write in phase 3
	assign fr_bank = bank_q;
	assign fr_addr = is_ind ? {6'h00, pidx} : faddr;
	assign fr_rd = exe && phase_q == `PH_READ && (names_file || is_ind);
	assign fr_wr = exe && q_end && wr_file;
	assign fr_wdata = res_q;

	// pointer updates: pre modes before the read, post modes at the end
	assign ptr_sel = n_eff;
	assign ptr_mode = pmode;
	assign ptr_ofs = is_ind_k || op == `OP_ADDFSR ? lit[5:0] : 6'h00;
	assign ptr_step = exe && is_ind_move &&
		(pmode[1] ? q_end : phase_q == 2'h0);
	assign ptr_add = exe && q_end && op == `OP_ADDFSR;

	// return stack traffic at the close of the executing cycle
	assign stack_push = exe && q_end && is_call;
	assign stack_ret_addr = pc_q;
	assign stack_pop = exe && q_end && is_ret;

	assign pm_addr = pc_q;
	assign osc_phase = phase_q;
	assign instr_cycle_end = q_end;
	assign retire = exe && q_end;
	assign retire_op = op;
	assign illegal_op = exe && q_end && op == `OP_ILLEGAL;
	assign int_exit = exe && q_end && op == `OP_INT_EXIT;
	assign acc = w_q;

	// result of the modify step on the value read from the file, or of the literal op on W
	always @* begin
		case (op)
			`OP_ADDWF: alu_d = w_q + fr_rdata;
			`OP_ADDWFC: alu_d = w_q + fr_rdata + {7'h00, carry_in};
			`OP_ANDWF: alu_d = w_q & fr_rdata;
			`OP_ASRF: alu_d = {fr_rdata[7], fr_rdata[7:1]};
			`OP_LSLF: alu_d = {fr_rdata[6:0], 1'b0};
			`OP_LSRF: alu_d = {1'b0, fr_rdata[7:1]};
			`OP_CLRF: alu_d = 8'h00;
			`OP_CLRW: alu_d = 8'h00;
			`OP_COMF: alu_d = ~fr_rdata;
			`OP_DECF: alu_d = fr_rdata - 8'h01;
			`OP_DEC_ZSKIP: alu_d = fr_rdata - 8'h01;
			`OP_INCF: alu_d = fr_rdata + 8'h01;
			`OP_INC_ZSKIP: alu_d = fr_rdata + 8'h01;
			`OP_IORWF: alu_d = w_q | fr_rdata;
			`OP_MOVF: alu_d = fr_rdata;
			`OP_RLF: alu_d = {fr_rdata[6:0], carry_in};
			`OP_RRF: alu_d = {carry_in, fr_rdata[7:1]};
			`OP_SUBWF: alu_d = fr_rdata - w_q;
			`OP_SUBWFB: alu_d = fr_rdata - w_q - {7'h00, ~carry_in};
			`OP_SWAPF: alu_d = {fr_rdata[3:0], fr_rdata[7:4]};
			`OP_XORWF: alu_d = w_q ^ fr_rdata;
			`OP_BCF: alu_d = fr_rdata & ~bit_mask(bsel);
			`OP_BSF: alu_d = fr_rdata | bit_mask(bsel);
			`OP_ADDLW: alu_d = w_q + lit[7:0];
			`OP_ANDLW: alu_d = w_q & lit[7:0];
			`OP_IORLW: alu_d = w_q | lit[7:0];
			`OP_MOVLW: alu_d = lit[7:0];
			`OP_SUBLW: alu_d = lit[7:0] - w_q;
			`OP_XORLW: alu_d = w_q ^ lit[7:0];
			`OP_LIT_RETURN: alu_d = lit[7:0];
			`OP_MOVIW: alu_d = fr_rdata;
			`OP_MOVIW_K: alu_d = fr_rdata;
			default: alu_d = w_q;
		endcase
	end

	// skip decision: zero result or tested bit state
	always @* begin
		case (op)
			`OP_DEC_ZSKIP: skip_d = alu_d == 8'h00;
			`OP_INC_ZSKIP: skip_d = alu_d == 8'h00;
			`OP_BIT_CLR_SKIP: skip_d = (fr_rdata & bit_mask(bsel)) == 8'h00;
			`OP_BIT_SET_SKIP: skip_d = (fr_rdata & bit_mask(bsel)) != 8'h00;
			default: skip_d = 1'b0;
		endcase
	end

	// control transfer targets
	always @* begin
		jump_d = 1'b1;
		case (op)
			`OP_ABS_JUMP: target_d = {pclath_q[6:3], lit};
			`OP_CALL: target_d = {pclath_q[6:3], lit};
			`OP_ACC_CALL: target_d = {pclath_q, w_q};
			`OP_PC_OFS_JUMP: target_d = pc_q + {{6{lit[8]}}, lit[8:0]};
			`OP_ACC_OFS_JUMP: target_d = pc_q + {7'h00, w_q};
			`OP_RETURN: target_d = stack_top;
			`OP_LIT_RETURN: target_d = stack_top;
			`OP_INT_EXIT: target_d = stack_top;
			default: begin
				jump_d = 1'b0;
				target_d = pc_q;
			end
		endcase
	end

	// four oscillator phases per cycle; fetch, execute, flush sequencing
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			phase_q <= 2'h0;
			st_q <= ST_FLUSH;
			pc_q <= `PC_RESET;
			ir_q <= `NOP_WORD;
			w_q <= 8'h00;
			pclath_q <= 7'h00;
			bank_q <= 5'h00;
			res_q <= 8'h00;
			skip_q <= 1'b0;
		end else begin
			phase_q <= phase_q + 2'h1;
			if (exe && phase_q == `PH_CALC) begin
				res_q <= alu_d;
				skip_q <= skip_d;
			end
			if (exe && q_end) begin
				if (wr_w)
					w_q <= res_q;
				if (op == `OP_MOVLP)
					pclath_q <= lit[6:0];
				if (op == `OP_MOVLB)
					bank_q <= lit[4:0];
			end
			if (q_end) begin
				case (st_q)
					ST_EXEC, ST_HOLD: begin
						if (st_q == ST_EXEC && need_extra) begin
							st_q <= ST_HOLD;
						end else if (jump_d) begin
							pc_q <= target_d;
							st_q <= ST_FLUSH;
						end else if (skip_q) begin
							pc_q <= pc_q + 15'h0001;
							st_q <= ST_FLUSH;
						end else begin
							ir_q <= pm_data;
							pc_q <= pc_q + 15'h0001;
							st_q <= ST_EXEC;
						end
					end
					ST_FLUSH: begin
						ir_q <= pm_data;
						pc_q <= pc_q + 15'h0001;
						st_q <= ST_EXEC;
					end
					default: st_q <= ST_FLUSH;
				endcase
			end
		end
	end

endmodule // core_instruction_timing_decode
`default_nettype wire

// >>> dv/core_instruction_timing_decode_checker.sv
// checker: cycle framing, strobe phases and transfer timing of the core
// assumes binding to the core's top ports, one clock and synchronous reset
`timescale 1ns/1ns
`default_nettype none
`include "core_timing_regs.vh"

module core_instruction_timing_decode_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// watched outputs
	input wire logic [14:0] pm_addr,
	input wire logic fr_rd,
	input wire logic fr_wr,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic ptr_step,
	input wire logic [1:0] ptr_mode,
	input wire logic [1:0] osc_phase,
	input wire logic instr_cycle_end,
	input wire logic retire,
	input wire logic [5:0] retire_op,
	input wire logic int_exit
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// transfer classes of the retiring operation
	wire is_call = retire_op == `OP_CALL || retire_op == `OP_ACC_CALL;
	wire is_ret = retire_op == `OP_RETURN || retire_op == `OP_LIT_RETURN
		|| retire_op == `OP_INT_EXIT;
	wire is_jump = retire_op == `OP_ABS_JUMP || retire_op == `OP_PC_OFS_JUMP
		|| retire_op == `OP_ACC_OFS_JUMP;

	// a whole instruction cycle that retires nothing
	sequence flush_cycle;
		(!retire)[*3] ##1 (instr_cycle_end && !retire);
	endsequence
	// three clocks between cycle ends
	sequence quiet_phases;
		(!instr_cycle_end)[*3];
	endsequence

	AST_CYCLE_FOUR: assert property (instr_cycle_end |=> quiet_phases ##1 instr_cycle_end)
		else $error("instruction cycle is not four clocks");
	AST_END_PHASE: assert property (instr_cycle_end == (osc_phase == `PH_LAST))
		else $error("cycle end off the last phase");
	AST_RETIRE_END: assert property (retire |-> instr_cycle_end)
		else $error("retire outside cycle end");
	AST_PM_STANDS: assert property (!instr_cycle_end |=> $stable(pm_addr))
		else $error("fetch address moved inside a cycle");
	AST_READ_FIRST: assert property (fr_wr |-> $past(fr_rd, 2))
		else $error("file write without earlier read");
	AST_RD_PHASE: assert property (fr_rd |-> osc_phase == `PH_READ)
		else $error("file read off its phase");
	AST_CALL_PUSH: assert property (stack_push == (retire && is_call))
		else $error("push does not match a call");
	AST_RET_POP: assert property (stack_pop == (retire && is_ret))
		else $error("pop does not match a return");
	AST_FLUSH: assert property (
		retire && (is_call || is_ret || is_jump) |=> flush_cycle)
		else $error("transfer not followed by a flush cycle");
	AST_INT_EXIT: assert property (int_exit |-> retire && retire_op == `OP_INT_EXIT)
		else $error("interrupt exit flag without its op");
	AST_STEP_PHASE: assert property (
		ptr_step |-> osc_phase == (ptr_mode[1] ? `PH_LAST : 2'h0))
		else $error("pointer step in wrong phase");
endmodule // core_instruction_timing_decode_checker

bind core_instruction_timing_decode core_instruction_timing_decode_checker checker_i (
	.ref_clk, .reset_n, .pm_addr, .fr_rd, .fr_wr, .stack_push, .stack_pop, .ptr_step,
	.ptr_mode, .osc_phase, .instr_cycle_end, .retire, .retire_op, .int_exit);

`default_nettype wire

// >>> dv/prog_file_model.sv
// partner: program memory, file space and return stack for the core
// assumes one-clock strobes synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none

module prog_file_model (
	// clock
	input wire logic ref_clk,
	// program memory
	input wire logic [14:0] pm_addr,
	output logic [13:0] pm_data,
	// file space
	input wire logic [6:0] fr_addr,
	input wire logic fr_rd,
	input wire logic fr_wr,
	input wire logic [7:0] fr_wdata,
	output logic [7:0] fr_rdata,
	// return stack
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic [14:0] stack_ret_addr,
	output logic [14:0] stack_top
);
	logic [13:0] pmem [0:255];
	logic [7:0] fmem [0:127];
	logic [14:0] stk [0:15];
	logic [3:0] sp_q = 4'h0;

	// word and stack top follow their pointers
	assign pm_data = pmem[pm_addr[7:0]];
	assign stack_top = stk[sp_q - 4'h1];

	// read data valid one clock after the strobe, scrambled otherwise
	always @(posedge ref_clk) begin
		fr_rdata <= (fr_rd === 1'b1) ? fmem[fr_addr] : ~fr_rdata;
		if (fr_wr === 1'b1) begin
			fmem[fr_addr] <= fr_wdata;
		end
		if (stack_push === 1'b1) begin
			stk[sp_q] <= stack_ret_addr;
			sp_q <= sp_q + 4'h1;
		end else if (stack_pop === 1'b1) begin
			sp_q <= sp_q - 4'h1;
		end
	end

	initial fr_rdata = 8'hA5;
endmodule // prog_file_model

`default_nettype wire

// >>> dv/core_instruction_timing_decode_test.sv
// self-checking bench: fixed program with random operands, retire order and timing
// assumes the partner model answers program, file and stack traffic
`timescale 1ns/1ns
`default_nettype none
`include "core_timing_regs.vh"

module core_instruction_timing_decode_test;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic carry_in = 1'b0;
	logic [1:0] ptr_in_pgm = 2'h0;
	wire [14:0] pm_addr, stack_ret_addr, stack_top;
	wire [13:0] pm_data;
	wire [6:0] fr_addr;
	wire [7:0] fr_wdata, fr_rdata, acc;
	wire [5:0] retire_op;
	wire [1:0] ptr_mode, osc_phase;
	wire fr_rd, fr_wr, ptr_step, ptr_sel, stack_push, stack_pop;
	wire instr_cycle_end, retire, int_exit, illegal_op;
	integer bad_count = 0, n_checks = 0, seed = 60915;
	integer clk_n = 0, last_ret = 0, n_ret = 0, run, span;
	logic [7:0] k, init1;
	logic [6:0] f1, f2, f3;
	logic [2:0] bit_pos;
	logic [1:0] update_mode;
	logic [5:0] exp_op [0:14] = '{`OP_MOVLW, `OP_ADDWF, `OP_MOVWF, `OP_DEC_ZSKIP,
		`OP_INC_ZSKIP, `OP_CALL, `OP_LIT_RETURN, `OP_ABS_JUMP, `OP_PC_OFS_JUMP,
		`OP_MOVIW, `OP_MOVF, `OP_BSF, `OP_BIT_SET_SKIP, `OP_ABS_JUMP, `OP_ABS_JUMP};
	integer exp_gap [0:14] = '{0, 1, 1, 1, 2, 1, 2, 2, 2, 2, 2, 1, 1, 2, 2};

	core_instruction_timing_decode core_instruction_timing_decode_i (.ref_clk, .reset_n,
		.pm_addr, .pm_data, .fr_bank(), .fr_addr, .fr_rd, .fr_wr, .fr_wdata, .fr_rdata,
		.carry_in, .ptr_in_pgm, .ptr_step, .ptr_add(), .ptr_sel, .ptr_mode, .ptr_ofs(),
		.stack_push, .stack_ret_addr, .stack_pop, .stack_top, .osc_phase, .instr_cycle_end,
		.retire, .retire_op, .illegal_op, .int_exit, .acc);

	prog_file_model prog_file_model_i (.ref_clk, .pm_addr, .pm_data, .fr_addr, .fr_rd,
		.fr_wr, .fr_wdata, .fr_rdata, .stack_push, .stack_pop, .stack_ret_addr, .stack_top);

	// clock of 20 ns
	always #10 ref_clk = ~ref_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// retire order, clocks between retirements, pointer step operands
	always @(negedge ref_clk) begin
		clk_n = clk_n + 1;
		if (reset_n && retire === 1'b1 && n_ret < 15) begin
			check(retire_op, exp_op[n_ret]);
			check(16'(illegal_op), 16'h0000);
			if (n_ret > 0) begin
				span = clk_n - last_ret;
				check(16'(span), 16'(4 * exp_gap[n_ret]));
			end
			last_ret = clk_n;
			n_ret = n_ret + 1;
		end
		if (reset_n && ptr_step === 1'b1)
			check({ptr_sel, ptr_mode}, {1'b1, update_mode});
	end

	// load a program with random operands, reset, run to the final loop
	task automatic run_once(input logic [1:0] mode);
		integer i;
		@(negedge ref_clk);
		reset_n = 1'b0;
		update_mode = mode;
		@(negedge ref_clk);
		for (i = 0; i < 256; i = i + 1) prog_file_model_i.pmem[i] = 14'h3000;
		for (i = 0; i < 128; i = i + 1) prog_file_model_i.fmem[i] = 8'($random(seed));
		k = 8'($random(seed));
		f1 = {3'h2, 4'($random(seed))};
		f2 = {3'h3, 4'($random(seed))};
		f3 = {3'h4, 4'($random(seed))};
		bit_pos = 3'($random(seed));
		prog_file_model_i.fmem[f3] = 8'h01;
		prog_file_model_i.fmem[7'h7F] = {1'b0, 7'($random(seed))};
		init1 = prog_file_model_i.fmem[f1];
		prog_file_model_i.pmem[0] = {6'h30, k};
		prog_file_model_i.pmem[1] = {7'h0F, f1};
		prog_file_model_i.pmem[2] = {7'h01, f2};
		prog_file_model_i.pmem[3] = {7'h16, f3};
		prog_file_model_i.pmem[5] = {7'h1E, 7'h7F};
		prog_file_model_i.pmem[6] = 14'h200A;
		prog_file_model_i.pmem[7] = 14'h280C;
		prog_file_model_i.pmem[10] = {6'h34, ~k};
		prog_file_model_i.pmem[12] = 14'h3201;
		prog_file_model_i.pmem[14] = {12'h005, mode};
		prog_file_model_i.pmem[15] = 14'h0800;
		// set a bit, test it and skip a clear of it, then loop on a jump
		prog_file_model_i.pmem[16] = {4'h5, bit_pos, f2};
		prog_file_model_i.pmem[17] = {4'h7, bit_pos, f2};
		prog_file_model_i.pmem[18] = {4'h4, bit_pos, f2};
		prog_file_model_i.pmem[19] = 14'h2813;
		ptr_in_pgm = 2'h1;
		carry_in = 1'($random(seed));
		n_ret = 0;
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		i = 0;
		while (n_ret < 15 && i < 400) begin
			@(negedge ref_clk);
			i = i + 1;
		end
		check(16'(n_ret), 16'h000F);
		check(prog_file_model_i.fmem[f1], 8'(init1 + k));
		check(prog_file_model_i.fmem[f2], k | (8'h01 << bit_pos));
		check(prog_file_model_i.fmem[f3], 8'h01);
		check(acc, prog_file_model_i.fmem[0]);
	endtask

	// four runs, one per pointer update mode, each behind a fresh reset
	initial begin
		for (run = 0; run < 4; run = run + 1) run_once(run[1:0]);
		conclude;
	end

	// watchdog well beyond four short runs
	initial begin
		#(20 * 5000);
		bad_count = bad_count + 1;
		conclude;
	end
endmodule // core_instruction_timing_decode_test

`default_nettype wire
